// file: src/pcsr_pkg.sv
/*
 * Constants shared by the serial register bank: register addresses,
 * field positions, reset values and serial frame counts.
 * Assumes a 13-bit register address carried in a 16-bit instruction.
 */
package pcsr_pkg;

    // ------------------------------------------------------------
    // Addresses and direct registers
    // ------------------------------------------------------------
    localparam int                ADDR_W   = 13;
    localparam logic [ADDR_W-1:0] A_CFG    = 13'h000;
    localparam logic [ADDR_W-1:0] A_RB     = 13'h004;
    localparam logic [ADDR_W-1:0] A_UPD    = 13'h005;
    localparam int                CFG_LSB  = 6;
    localparam int                CFG_MRST = 5;
    localparam int                RB_SEL   = 0;
    localparam int                UPD_GO   = 0;
    localparam int                CMD_RW   = 15;
    localparam logic              CFG_B7   = 1'b0;
    localparam logic              CFG_B4   = 1'b1;
    localparam logic [7:0]        READ_IDLE = 8'h00;

    // ------------------------------------------------------------
    // Buffered registers, index 0 last
    // ------------------------------------------------------------
    localparam int BUF_N  = 12;
    localparam int I_FRH  = 0;
    localparam int I_FRM  = 1;
    localparam int I_FRL  = 2;
    localparam int I_DIV  = 3;
    localparam int I_DEN  = 4;
    localparam int I_RXBG = 5;
    localparam int I_XT   = 6;
    localparam int I_XSEL = 8;
    localparam int I_D1   = 9;
    localparam int I_SRC  = 10;
    localparam int I_D2   = 11;
    localparam logic [BUF_N-1:0][ADDR_W-1:0] BUF_ADDR = {
        13'h034, 13'h033, 13'h032, 13'h01d, 13'h01c, 13'h01b,
        13'h01a, 13'h019, 13'h018, 13'h017, 13'h016, 13'h015};
    localparam logic [BUF_N-1:0][7:0] BUF_RST = {
        8'ha8, 8'h00, 8'ha8, 8'h00, 8'h00, 8'h80,
        8'h00, 8'h20, 8'h00, 8'h01, 8'h00, 8'h20};
    localparam logic [BUF_N-1:0][7:0] BUF_MASK = {
        8'hff, 8'h08, 8'hff, 8'h05, 8'h00, 8'hbf,
        8'hfd, 8'h80, 8'hff, 8'hf1, 8'hff, 8'hff};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FRL_LO  = 4;
    localparam int P1_MSB  = 0;
    localparam int P1_LO   = 3;
    localparam int P0_HI   = 2;
    localparam int DEN_BIT = 7;
    localparam int RX_RST  = 7;
    localparam int BG_HI   = 6;
    localparam int BG_LO   = 2;
    localparam int BG_EN   = 0;
    localparam int XT_DIS  = 7;
    localparam int XT_HI   = 5;
    localparam int XS_DBL  = 2;
    localparam int XS_CRYSTAL_INPUT = 0;
    localparam int SRC_BIT = 3;

    // ------------------------------------------------------------
    // Serial frame counts, in link clock edges
    // ------------------------------------------------------------
    localparam int INSTR_BITS = 16;
    localparam int DATA_BITS  = 8;
    localparam int RD_GAP     = 16;
    localparam int CNT_W      = 6;
    localparam logic [CNT_W-1:0] C_INS_END  = CNT_W'(INSTR_BITS - 1);
    localparam logic [CNT_W-1:0] C_WR_END   =
        CNT_W'(INSTR_BITS + DATA_BITS - 1);
    localparam logic [CNT_W-1:0] C_RD_LOAD  = CNT_W'(INSTR_BITS + RD_GAP - 1);
    localparam logic [CNT_W-1:0] C_RD_FIRST = CNT_W'(INSTR_BITS + RD_GAP);
    localparam logic [CNT_W-1:0] C_RD_LAST  =
        CNT_W'(INSTR_BITS + RD_GAP + DATA_BITS - 1);
    localparam logic [CNT_W-1:0] C_MAX      = '1;

endpackage : pcsr_pkg

// file: src/pcsr_link_if.sv
/*
 * Crossing bundle between the serial link logic and the register core.
 * Assumes toggles are synchronised on the receiving side and the words
 * beside them stay still until the toggle has been seen.
 */
`timescale 1ns/1ps
`default_nettype none
interface pcsr_link_if import pcsr_pkg::*; ();
    logic              wr_tgl;
    logic              rd_tgl;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic              ack_tgl;
    logic              lsb_first;

    modport link (
        output wr_tgl, rd_tgl, addr, wdata,
        input  rdata, ack_tgl, lsb_first
    );
    modport core (
        input  wr_tgl, rd_tgl, addr, wdata,
        output rdata, ack_tgl, lsb_first
    );
endinterface : pcsr_link_if
`default_nettype wire

// file: src/pcsr_spi_link.sv
/*
 * Three-wire serial front end, clocked by the host's serial clock.
 * Assumes the clock runs only inside frames and chip select is high
 * between frames; one register per frame.
 */
`timescale 1ns/1ps
`default_nettype none
module pcsr_spi_link import pcsr_pkg::*; (
    // Link pins
    input  wire logic   sclk,
    input  wire logic   csb,
    input  wire logic   sdio_in,
    output logic        sdio_out,
    output logic        sdio_oe,
    // Reset
    input  wire logic   rst_n,
    // Core side
    pcsr_link_if.link   lk
);

    logic             frame_rst;
    logic [CNT_W-1:0] cnt_r,   cnt_nxt;
    logic [15:0]      ins_r,   ins_nxt;
    logic [7:0]       dat_r,   dat_nxt;
    logic             rd_r,    rd_nxt;
    logic [7:0]       word_r,  word_nxt;
    logic [1:0]       lsb_s_r, lsb_s_nxt;
    logic [1:0]       ack_s_r, ack_s_nxt;
    logic             wrt_r,   wrt_nxt;
    logic             rdt_r,   rdt_nxt;
    logic [ADDR_W-1:0] adr_r,  adr_nxt;
    logic [7:0]       wd_r,    wd_nxt;
    logic             out_r,   out_nxt;
    logic             oe_r,    oe_nxt;
    logic [15:0]      instr_raw;
    logic [15:0]      instr;
    logic [7:0]       dbyte;
    logic             lsb;

    // The frame logic starts clean on every chip select.
    assign frame_rst = csb | ~rst_n;
    assign lsb       = lsb_s_r[1];
    assign instr_raw = {ins_r[14:0], sdio_in};
    assign dbyte     = {dat_r[6:0], sdio_in};

    assign instr = lsb ? {<<{instr_raw}} : instr_raw;

    // ------------------------------------------------------------
    // Frame shifting
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt   = (cnt_r == C_MAX) ? cnt_r : cnt_r + 1'b1;
        ins_nxt   = (cnt_r <= C_INS_END) ? instr_raw : ins_r;
        dat_nxt   = dbyte;
        rd_nxt    = rd_r;
        word_nxt  = word_r;
        lsb_s_nxt = {lsb_s_r[0], lk.lsb_first};
        ack_s_nxt = {ack_s_r[0], lk.ack_tgl};
        if (cnt_r == C_INS_END) begin
            rd_nxt = instr[CMD_RW];
        end
        // A late core answer reads as zero rather than stale data.
        if (rd_r && cnt_r == C_RD_LOAD) begin
            if (ack_s_r[1] == rdt_r) begin
                word_nxt = lsb ? {<<{lk.rdata}} : lk.rdata;
            end else begin
                word_nxt = READ_IDLE;
            end
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_r   <= '0;
            ins_r   <= '0;
            dat_r   <= '0;
            rd_r    <= 1'b0;
            word_r  <= '0;
            lsb_s_r <= '0;
            ack_s_r <= '0;
        end else begin
            cnt_r   <= cnt_nxt;
            ins_r   <= ins_nxt;
            dat_r   <= dat_nxt;
            rd_r    <= rd_nxt;
            word_r  <= word_nxt;
            lsb_s_r <= lsb_s_nxt;
            ack_s_r <= ack_s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Requests to the core
    // ------------------------------------------------------------
    always_comb begin
        wrt_nxt = wrt_r;
        rdt_nxt = rdt_r;
        adr_nxt = adr_r;
        wd_nxt  = wd_r;
        if (cnt_r == C_INS_END) begin
            adr_nxt = instr[ADDR_W-1:0];
            if (instr[CMD_RW]) begin
                rdt_nxt = ~rdt_r;
            end
        end
        if (!rd_r && cnt_r == C_WR_END) begin
            wd_nxt  = lsb ? {<<{dbyte}} : dbyte;
            wrt_nxt = ~wrt_r;
        end
    end

    // Toggles survive chip select so the core never sees a false event.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            wrt_r <= 1'b0;
            rdt_r <= 1'b0;
            adr_r <= '0;
            wd_r  <= '0;
        end else begin
            wrt_r <= wrt_nxt;
            rdt_r <= rdt_nxt;
            adr_r <= adr_nxt;
            wd_r  <= wd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data driven on the falling edge
    // ------------------------------------------------------------
    always_comb begin
        oe_nxt  = rd_r && cnt_r >= C_RD_FIRST && cnt_r <= C_RD_LAST;
        out_nxt = oe_nxt ? word_r[3'(C_RD_LAST - cnt_r)] : 1'b0;
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            out_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            out_r <= out_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign sdio_out  = out_r;
    assign sdio_oe   = oe_r;
    assign lk.wr_tgl = wrt_r;
    assign lk.rd_tgl = rdt_r;
    assign lk.addr   = adr_r;
    assign lk.wdata  = wd_r;

endmodule : pcsr_spi_link
`default_nettype wire

// file: src/pcsr_regmap.sv
/*
 * Serial-programmed control register bank of a fractional-N clock
 * generator: serial port control, readback select, buffer transfer and
 * the buffered control registers with their active copies.
 * Assumes a three-wire host on sclk/csb/sdio and a free-running clk.
 */
// Behaviour
// - Config bit 7 always reads zero.
// - Config bit 6 chooses LSB-first transfer order.
// - Config bit 5 resets map, then clears.
// - Config bit 4 always reads one.
// - Config bits 3:0 mirror bits 7:4.
// - Readback bit picks active or buffered value.
// - Update bit copies buffers to active, clears.
// - Control bits are active high, except the crystal tuning disable bit.
// - Bandgap adjust inverted scale, default zero.
// - Primary divider split across two registers.
// - Driver registers hold five fields, default 0xa8.
// - Self-clearing bits return to zero after acting.
`timescale 1ns/1ps
`default_nettype none
module pcsr_regmap import pcsr_pkg::*; (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // Serial link pins
    input  wire logic   sclk,
    input  wire logic   csb,
    input  wire logic   sdio_in,
    output logic        sdio_out,
    output logic        sdio_oe,
    // Loop and divider controls
    output logic [19:0] modulator_fraction,
    output logic [5:0]  primary_output_divider,
    output logic [2:0]  secondary_output_divider,
    output logic        primary_divider_spi_en,
    // Receiver and reference voltage
    output logic        receiver_reset,
    output logic [4:0]  bandgap_adjust,
    output logic        bandgap_spi_en,
    // Crystal input
    output logic        crystal_tuning_spi_dis,
    output logic [5:0]  crystal_cap,
    output logic        crystal_doubler,
    output logic        crystal_input_use,
    // Output drivers
    output logic [7:0]  primary_driver_config,
    output logic        secondary_output_source,
    output logic [7:0]  secondary_driver_config
);

    pcsr_link_if lk ();

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    pcsr_spi_link u_link (
        .sclk     (sclk),
        .csb      (csb),
        .sdio_in  (sdio_in),
        .sdio_out (sdio_out),
        .sdio_oe  (sdio_oe),
        .rst_n    (rst_n),
        .lk       (lk.link)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] buf_index(
        input logic [ADDR_W-1:0] a
    );
        buf_index = 4'(BUF_N);
        for (int i = 0; i < BUF_N; i++) begin
            if (BUF_ADDR[i] == a) begin
                buf_index = 4'(i);
            end
        end
    endfunction : buf_index

    function automatic logic [7:0] merge(
        input logic [7:0] old,
        input logic [7:0] d,
        input logic [7:0] m
    );
        merge = (old & ~m) | (d & m);
    endfunction : merge

    // ------------------------------------------------------------
    // Event synchronisers
    // ------------------------------------------------------------
    logic [2:0] wr_s_r, wr_s_nxt;
    logic [2:0] rd_s_r, rd_s_nxt;
    logic       wr_ev;
    logic       rd_ev;

    always_comb begin
        wr_s_nxt = {wr_s_r[1:0], lk.wr_tgl};
        rd_s_nxt = {rd_s_r[1:0], lk.rd_tgl};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_s_r <= '0;
            rd_s_r <= '0;
        end else begin
            wr_s_r <= wr_s_nxt;
            rd_s_r <= rd_s_nxt;
        end
    end

    // Address and data from the link stay still long after the toggle.
    assign wr_ev = wr_s_r[2] ^ wr_s_r[1];
    assign rd_ev = rd_s_r[2] ^ rd_s_r[1];

    // ------------------------------------------------------------
    // Register core
    // ------------------------------------------------------------
    logic                  lsb_r,   lsb_nxt;
    logic                  mrst_r,  mrst_nxt;
    logic                  rbsel_r, rbsel_nxt;
    logic                  upd_r,   upd_nxt;
    logic [BUF_N-1:0][7:0] buf_r,   buf_nxt;
    logic [BUF_N-1:0][7:0] act_r,   act_nxt;
    logic [7:0]            rdat_r,  rdat_nxt;
    logic                  ack_r,   ack_nxt;
    logic [3:0]            idx;
    logic                  hit;

    assign idx = buf_index(lk.addr);
    assign hit = idx < 4'(BUF_N);

    always_comb begin
        lsb_nxt   = lsb_r;
        mrst_nxt  = 1'b0;
        rbsel_nxt = rbsel_r;
        upd_nxt   = 1'b0;
        buf_nxt   = buf_r;
        act_nxt   = act_r;
        rdat_nxt  = rdat_r;
        ack_nxt   = ack_r;
        act_nxt[I_RXBG][RX_RST] = 1'b0;
        if (upd_r) begin
            act_nxt = buf_r;
            buf_nxt[I_RXBG][RX_RST] = 1'b0;
        end
        if (wr_ev) begin
            unique case (lk.addr)
                A_CFG: begin
                    lsb_nxt  = lk.wdata[CFG_LSB];
                    mrst_nxt = lk.wdata[CFG_MRST];
                end
                A_RB: begin
                    rbsel_nxt = lk.wdata[RB_SEL];
                end
                A_UPD: begin
                    upd_nxt = lk.wdata[UPD_GO];
                end
                default: begin
                    if (hit) begin
                        buf_nxt[idx] = merge(buf_r[idx], lk.wdata,
                                             BUF_MASK[idx]);
                    end
                end
            endcase
        end
        if (rd_ev) begin
            ack_nxt = ~ack_r;
            unique case (lk.addr)
                A_CFG: begin
                    rdat_nxt = {CFG_B7, lsb_r, mrst_r, CFG_B4,
                                CFG_B4, mrst_r, lsb_r, CFG_B7};
                end
                A_RB: begin
                    rdat_nxt = {7'h00, rbsel_r};
                end
                A_UPD: begin
                    rdat_nxt = {7'h00, upd_r};
                end
                default: begin
                    if (hit) begin
                        rdat_nxt = rbsel_r ? buf_r[idx] : act_r[idx];
                    end else begin
                        rdat_nxt = READ_IDLE;
                    end
                end
            endcase
        end
        // map reset acts and clears itself.
        if (mrst_r) begin
            lsb_nxt   = 1'b0;
            rbsel_nxt = 1'b0;
            upd_nxt   = 1'b0;
            buf_nxt   = BUF_RST;
            act_nxt   = BUF_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lsb_r   <= 1'b0;
            mrst_r  <= 1'b0;
            rbsel_r <= 1'b0;
            upd_r   <= 1'b0;
            buf_r   <= BUF_RST;
            act_r   <= BUF_RST;
            rdat_r  <= READ_IDLE;
            ack_r   <= 1'b0;
        end else begin
            lsb_r   <= lsb_nxt;
            mrst_r  <= mrst_nxt;
            rbsel_r <= rbsel_nxt;
            upd_r   <= upd_nxt;
            buf_r   <= buf_nxt;
            act_r   <= act_nxt;
            rdat_r  <= rdat_nxt;
            ack_r   <= ack_nxt;
        end
    end

    assign lk.rdata     = rdat_r;
    assign lk.ack_tgl   = ack_r;
    assign lk.lsb_first = lsb_r;

    // ------------------------------------------------------------
    // Active control fields
    // ------------------------------------------------------------
    // fields pass with their stored sense.
    assign modulator_fraction = {act_r[I_FRH], act_r[I_FRM],
                                 act_r[I_FRL][7:FRL_LO]};
    assign primary_output_divider = {act_r[I_FRL][P1_MSB],
                                     act_r[I_DIV][7:P1_LO]};
    assign secondary_output_divider = act_r[I_DIV][P0_HI:0];
    assign primary_divider_spi_en   = act_r[I_DEN][DEN_BIT];
    assign receiver_reset           = act_r[I_RXBG][RX_RST];
    // zero is the highest voltage, left unconverted.
    assign bandgap_adjust = act_r[I_RXBG][BG_HI:BG_LO];
    assign bandgap_spi_en = act_r[I_RXBG][BG_EN];
    // This bit is the one control with inverted sense.
    assign crystal_tuning_spi_dis = act_r[I_XT][XT_DIS];
    assign crystal_cap       = act_r[I_XT][XT_HI:0];
    assign crystal_doubler   = act_r[I_XSEL][XS_DBL];
    assign crystal_input_use = act_r[I_XSEL][XS_CRYSTAL_INPUT];
    assign primary_driver_config   = act_r[I_D1];
    assign secondary_output_source = act_r[I_SRC][SRC_BIT];
    assign secondary_driver_config = act_r[I_D2];

endmodule : pcsr_regmap
`default_nettype wire

// file: test/pcsr_spi_host.sv
/*
 * Behavioural three-wire host that frames reads and writes.
 * Assumes the bench sets lsb to match the bit order the bank expects.
 */
`timescale 1ns/1ps
`default_nettype none
module pcsr_spi_host (
    // Link pins
    output logic      sclk,
    output logic      csb,
    output logic      sdio_w,
    // Device drive
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    logic hd;
    logic lsb;

    assign sdio_w = sdio_oe ? sdio_out : hd;

    initial begin
        sclk = 1'b0;
        csb  = 1'b1;
        hd   = 1'b0;
        lsb  = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame
    // ------------------------------------------------------------
    task automatic bitx(input logic b);
        hd = b;
        #15 sclk = 1'b1;
        #15 sclk = 1'b0;
    endtask : bitx

    task automatic xfer(input logic rd, input logic [12:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] ins;
        ins = {rd, 2'b00, a};
        q = 8'h00;
        csb = 1'b0;
        #15;
        for (int i = 0; i < 16; i++) bitx(lsb ? ins[i] : ins[15-i]);
        if (!rd) begin
            for (int i = 0; i < 8; i++) bitx(lsb ? d[i] : d[7-i]);
        end else begin
            // Released line toggles so a stale level never reads back.
            for (int i = 0; i < 16; i++) bitx(~hd);
            for (int i = 0; i < 8; i++) begin
                hd = ~hd;
                #15 sclk = 1'b1;
                q[lsb ? i : 7-i] = sdio_w;
                #15 sclk = 1'b0;
            end
        end
        #15 csb = 1'b1;
        hd = ~hd;
        #240;
    endtask : xfer
endmodule : pcsr_spi_host
`default_nettype wire

// file: test/pcsr_regmap_properties.sv
/*
 * Port-level checks of the register bank.
 * Assumes frames are at least ten core cycles apart.
 */
`timescale 1ns/1ps
`default_nettype none
module pcsr_regmap_properties (
    // Clocks and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclk,
    input  wire logic       csb,
    // Watched outputs
    input  wire logic       sdio_oe,
    input  wire logic       receiver_reset,
    input  wire logic [7:0] primary_driver_config,
    input  wire logic [7:0] secondary_driver_config,
    input  wire logic [5:0] primary_output_divider,
    input  wire logic [4:0] bandgap_adjust,
    input  wire logic [19:0] modulator_fraction
);
    logic [3:0] oe_cnt_r;
    logic [3:0] oe_cnt_nxt;

    always_comb begin
        oe_cnt_nxt = 4'h0;
        if (sdio_oe) begin
            oe_cnt_nxt = (oe_cnt_r == 4'hf) ? oe_cnt_r : oe_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_cnt_r <= 4'h0;
        end else begin
            oe_cnt_r <= oe_cnt_nxt;
        end
    end

    sequence s_read_drive;
        sdio_oe [*8];
    endsequence

    chk_oe_idle_csb: assert property (@(posedge clk) disable iff (!rst_n)
        csb |-> !sdio_oe) else $error("data line driven while deselected");
    chk_oe_bounded: assert property (@(posedge clk) disable iff (!rst_n)
        oe_cnt_r <= 4'hb) else $error("data line driven too long");
    chk_read_drive: assert property (@(posedge sclk) disable iff (!rst_n || csb)
        $rose(sdio_oe) |-> s_read_drive) else $error("read byte cut short");
    chk_rx_one_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        receiver_reset |=> !receiver_reset) else $error("receiver reset held");
    chk_rx_after_frame: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(receiver_reset) |-> csb && $past(csb, 2))
        else $error("receiver reset inside a frame");
    chk_drv_defaults: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> primary_driver_config == 8'ha8 &&
        secondary_driver_config == 8'ha8) else $error("driver default wrong");
    chk_loop_defaults: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> primary_output_divider == 6'h20 &&
        bandgap_adjust == 5'h00 && modulator_fraction == 20'h20000)
        else $error("loop default wrong");
    chk_quiet_in_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (!csb) [*8] |-> $stable(primary_driver_config) &&
        $stable(primary_output_divider)) else $error("output moved in frame");
endmodule : pcsr_regmap_properties

bind pcsr_regmap pcsr_regmap_properties chk_u (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .csb(csb), .sdio_oe(sdio_oe),
    .receiver_reset(receiver_reset),
    .primary_driver_config(primary_driver_config),
    .secondary_driver_config(secondary_driver_config),
    .primary_output_divider(primary_output_divider),
    .bandgap_adjust(bandgap_adjust),
    .modulator_fraction(modulator_fraction)
);
`default_nettype wire

// file: test/pcsr_regmap_tb_top.sv
/*
 * Self-checking bench: serial reads and writes with expected values.
 * Assumes the host model frames every access and spaces the frames.
 */
`timescale 1ns/1ps
`default_nettype none
module pcsr_regmap_tb_top;
    logic clk, rst_n, sclk, csb, sdio_w, sdio_out, sdio_oe;
    logic [19:0] mf;
    logic [5:0]  pod, xcap;
    logic [2:0]  sod;
    logic [4:0]  bga;
    logic [7:0]  d1, d2;
    logic pde, rxr, bgen, xtd, xdbl, xuse, src;
    int err_total, num_checks;

    pcsr_spi_host host_u (.sclk(sclk), .csb(csb), .sdio_w(sdio_w),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe));
    pcsr_regmap dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csb(csb),
        .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .modulator_fraction(mf), .primary_output_divider(pod),
        .secondary_output_divider(sod), .primary_divider_spi_en(pde),
        .receiver_reset(rxr), .bandgap_adjust(bga), .bandgap_spi_en(bgen),
        .crystal_tuning_spi_dis(xtd), .crystal_cap(xcap),
        .crystal_doubler(xdbl), .crystal_input_use(xuse),
        .primary_driver_config(d1), .secondary_output_source(src),
        .secondary_driver_config(d2));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [19:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        @(negedge clk);
        host_u.xfer(1'b0, a, d, q);
    endtask : wr

    task automatic rd(input logic [12:0] a, input logic [7:0] e,
                      input string n);
        logic [7:0] q;
        @(negedge clk);
        host_u.xfer(1'b1, a, 8'h00, q);
        check(n, q, e);
    endtask : rd

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("p_div", pod, 6'h20);
        check("bg_adj", bga, 5'h00);
        check("drv1", d1, 8'ha8);
        check("drv2", d2, 8'ha8);
        check("xt_dis", xtd, 1'b1);
        check("div_en", pde, 1'b0);
        rd(13'h000, 8'h18, "cfg");
        wr(13'h000, 8'hcf);
        host_u.lsb = 1'b1;
        rd(13'h000, 8'h5a, "cfg_lsb");
        wr(13'h018, 8'hab);
        check("p_div_held", pod, 6'h20);
        rd(13'h018, 8'h00, "rb_active");
        wr(13'h004, 8'h01);
        rd(13'h018, 8'hab, "rb_buffer");
        wr(13'h005, 8'h01);
        check("p_div", pod, 6'h35);
        check("s_div", sod, 3'h3);
        rd(13'h005, 8'h00, "upd_clear");
        wr(13'h01a, 8'hfd);
        wr(13'h005, 8'h01);
        check("bg_adj", bga, 5'h1f);
        check("bg_en", bgen, 1'b1);
        check("rx_rst", rxr, 1'b0);
        rd(13'h01a, 8'h7d, "rx_buf");
        wr(13'h032, 8'h57);
        wr(13'h034, 8'h13);
        wr(13'h01b, 8'h3f);
        wr(13'h01d, 8'h05);
        wr(13'h033, 8'h08);
        wr(13'h017, 8'hf0);
        wr(13'h019, 8'h80);
        wr(13'h005, 8'h01);
        check("drv1", d1, 8'h57);
        check("drv2", d2, 8'h13);
        check("xt_cap", {xtd, xcap}, 7'h3f);
        check("xt_sel", {xdbl, xuse, src}, 3'h7);
        check("p_div", pod, 6'h15);
        check("modulator_fraction", mf, 20'h2000f);
        check("div_en", pde, 1'b1);
        wr(13'h00a, 8'h55);
        rd(13'h00a, 8'h00, "unmapped");
        wr(13'h000, 8'h20);
        host_u.lsb = 1'b0;
        rd(13'h000, 8'h18, "cfg_reset");
        rd(13'h004, 8'h00, "rb_reset");
        check("drv1", d1, 8'ha8);
        check("p_div", pod, 6'h20);
        complete_run();
    end
endmodule : pcsr_regmap_tb_top
`default_nettype wire
